//--- rtl/abhl_cfg_if.sv
// Purpose: Carries slot writes, readback and code lookup to the slot file
// Assumes: Single clock domain shared with the top
// Notes:   Lookup is combinational on the slot side
`timescale 1ns/1ps
interface abhl_cfg_if;
  logic        wr_sel;     // Write a select slot
  logic        wr_type;    // Write a type slot
  logic [4:0]  idx;        // Slot index for write and read
  logic [31:0] wr_data;    // Write data
  logic [3:0]  wr_be;      // Byte enables
  logic [31:0] rd_sel;     // Selected slot code readback
  logic [31:0] rd_type;    // Selected slot type readback
  logic [15:0] look_code;  // Code to classify
  logic [1:0]  look_type;  // Resulting message type
  modport host  (output wr_sel, wr_type, idx, wr_data, wr_be, look_code,
                 input rd_sel, rd_type, look_type);
  modport slots (input wr_sel, wr_type, idx, wr_data, wr_be, look_code,
                 output rd_sel, rd_type, look_type);
endinterface

//--- rtl/abhl_pkg.sv
// Purpose: Shared constants and types of the alarm buffer and history logger
// Assumes: One 40 MHz clock; 32-bit classic Wishbone register access
// Notes:   Buffer rows are 0..7, history rows are 8..63 of one entry store
package abhl_pkg;
  // Store geometry
  localparam int BUF_DEPTH  = 8;   // Buffer rows
  localparam int HIST_DEPTH = 56;  // History rows
  localparam int HIST_FIRST = 8;   // Newest history row
  localparam int TOTAL_ROWS = BUF_DEPTH + HIST_DEPTH;
  localparam int RECLASS_SLOTS = 20;
  localparam int CODE_W = 16;
  localparam int ROW_W  = 6;

  // Message types of a reclassification slot
  localparam logic [1:0] MSG_FAULT = 2'h1;
  localparam logic [1:0] MSG_ALARM = 2'h2;
  localparam logic [1:0] MSG_NONE  = 2'h3;

  // Status word layout and panel letter
  localparam int STATUS_ALARM_BIT = 7;
  localparam logic [7:0] PANEL_LETTER = 8'h41;

  // Runtime timing
  localparam int CLK_HZ      = 40_000_000;
  localparam int MS_PER_SEC  = 1000;
  localparam int CYC_PER_MS  = CLK_HZ / MS_PER_SEC;
  localparam logic [31:0] MS_PER_DAY = 32'h0526_5C00;

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS    = 8'h00;
  localparam logic [7:0] OFS_COUNTER   = 8'h04;
  localparam logic [7:0] OFS_LATEST    = 8'h08;
  localparam logic [7:0] OFS_BUF_COUNT = 8'h0C;
  localparam logic [7:0] OFS_ROW_SEL   = 8'h10;
  localparam logic [7:0] OFS_CODE      = 8'h14;
  localparam logic [7:0] OFS_VAL_INT   = 8'h18;
  localparam logic [7:0] OFS_VAL_FLT   = 8'h1C;
  localparam logic [7:0] OFS_RX_DAYS   = 8'h20;
  localparam logic [7:0] OFS_RX_MS     = 8'h24;
  localparam logic [7:0] OFS_RM_DAYS   = 8'h28;
  localparam logic [7:0] OFS_RM_MS     = 8'h2C;
  localparam logic [7:0] OFS_ROW_FLAGS = 8'h30;
  localparam logic [7:0] OFS_SEL_BASE  = 8'h40;
  localparam logic [7:0] OFS_TYPE_BASE = 8'h90;

  // One stored alarm
  typedef struct packed {
    logic              valid;
    logic              removed;
    logic [CODE_W-1:0] code;
    logic [31:0]       vint;
    logic [31:0]       vflt;
    logic [15:0]       rx_days;
    logic [31:0]       rx_ms;
    logic [15:0]       rm_days;
    logic [31:0]       rm_ms;
  } abhl_entry_t;

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] abhl_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction
endpackage

//--- rtl/abhl_reclass.sv
// Purpose: Twenty slots that change the message type of chosen alarms
// Assumes: Writes arrive as one-cycle strobes from the register slave
// Notes:   Unmatched codes, or slots still at reset, classify as alarm
`timescale 1ns/1ps
module abhl_reclass (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Slot access and lookup
  abhl_cfg_if.slots        cfg
);
  import abhl_pkg::*;

  logic [15:0] sel_r  [RECLASS_SLOTS];  // Chosen alarm numbers
  logic [1:0]  type_r [RECLASS_SLOTS];  // Message type per slot
  logic [RECLASS_SLOTS-1:0] hit;        // Slot matches lookup code

  // One slot per iteration
  for (genvar s = 0; s < RECLASS_SLOTS; s++) begin : g_slot
    assign hit[s] = (sel_r[s] == cfg.look_code) && (type_r[s] != MSG_ALARM);
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        sel_r[s]  <= 16'h0000;
        type_r[s] <= MSG_ALARM;
      end else if (cfg.idx == 5'(s)) begin
        if (cfg.wr_sel) begin
          sel_r[s] <= 16'(abhl_merge(32'(sel_r[s]), cfg.wr_data, cfg.wr_be));
        end
        if (cfg.wr_type && cfg.wr_be[0] && cfg.wr_data[1:0] != 2'h0) begin
          type_r[s] <= cfg.wr_data[1:0];
        end
      end
    end
  end

  // Lowest matching slot wins; type codes 1..3 only
  always_comb begin
    cfg.look_type = MSG_ALARM;
    for (int s = RECLASS_SLOTS - 1; s >= 0; s--) begin
      if (hit[s]) begin
        cfg.look_type = type_r[s];
      end
    end
  end

  // Readback of the indexed slot
  wire idx_ok = (cfg.idx < 5'(RECLASS_SLOTS));
  assign cfg.rd_sel  = idx_ok ? 32'(sel_r[cfg.idx])  : 32'h0000_0000;
  assign cfg.rd_type = idx_ok ? 32'(type_r[cfg.idx]) : 32'h0000_0000;
endmodule

//--- rtl/abhl_runtime.sv
// Purpose: Internal runtime in days and milliseconds for timestamps
// Assumes: Clock at the rate the divider parameter is set for
// Notes:   Millisecond count wraps into a day at the end of each day
`timescale 1ns/1ps
module abhl_runtime #(
  parameter int CYC_MS = abhl_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Runtime
  output logic [15:0]      o_days,
  output logic [31:0]      o_ms
);
  import abhl_pkg::*;

  logic [31:0] div_r;  // Cycles within current millisecond
  wire  ms_tick  = (div_r == 32'(CYC_MS - 1));
  wire  day_roll = ms_tick && (o_ms == MS_PER_DAY - 32'h0000_0001);

  // Divider and runtime counters
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_r  <= 32'h0000_0000;
      o_ms   <= 32'h0000_0000;
      o_days <= 16'h0000;
    end else begin
      div_r <= ms_tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
      if (day_roll) begin
        o_ms   <= 32'h0000_0000;
        o_days <= o_days + 16'h0001;
      end else if (ms_tick) begin
        o_ms <= o_ms + 32'h0000_0001;
      end
    end
  end
endmodule

//--- rtl/abhl_top.sv
// Purpose: Alarm buffer, alarm history, counter and reclassification
// Assumes: Alarm and clear inputs synchronous; taken only while ready
// Notes:   Migration walks the buffer one row per clock
`timescale 1ns/1ps

// Operation
// - Alarms logged, drive untouched unless reclassified
// - Alarm marked gone when cause clears
// - No acknowledge needed to clear alarm
// - Active alarm shown on status bit 7
// - Panel shows letter A plus alarm number
// - Entry: code, int, float, two split times
// - Timestamps come from internal runtime counter
// - Buffer holds at most eight alarms
// - Buffer ordered; full without room overwrites 7
// - Full buffer plus new alarm migrates removed
// - History shifts older from 8, oldest dropped
// - Removed entries copied; active stay in buffer
// - Buffer compacted upward over migrated gaps
// - New alarm stored as newest buffer entry
// - History holds at most fifty-six alarms
// - History ordered, newest at index 8
// - Counter counts alarms; zero write migrates
// - Latest alarm code register kept
// - Twenty slots select alarms to reclassify
// - Type 1 fault, 2 alarm, 3 none
module abhl_top #(
  parameter int CYC_MS = abhl_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                       I_CLOCK,
  input  wire logic                       I_RST,
  // Wishbone slave
  input  wire logic                       I_WB_CYC,
  input  wire logic                       I_WB_STB,
  input  wire logic                       I_WB_WE,
  input  wire logic [7:0]                 I_WB_ADR,
  input  wire logic [3:0]                 I_WB_SEL,
  input  wire logic [31:0]                I_WB_DAT,
  output logic [31:0]                     O_WB_DAT,
  output logic                            O_WB_ACK,
  // Alarm raise
  input  wire logic                       I_ALM_VALID,
  input  wire logic [abhl_pkg::CODE_W-1:0] I_ALM_CODE,
  input  wire logic [31:0]                I_ALM_VAL_INT,
  input  wire logic [31:0]                I_ALM_VAL_FLT,
  // Alarm cause cleared
  input  wire logic                       I_CLR_VALID,
  input  wire logic [abhl_pkg::CODE_W-1:0] I_CLR_CODE,
  output logic                            O_ALM_READY,
  // Indication
  output logic                            O_ALARM_ACTIVE,
  output logic [7:0]                      O_PANEL_LETTER,
  output logic [abhl_pkg::CODE_W-1:0]     O_PANEL_NUM,
  output logic                            O_FAULT_STB,
  output logic [abhl_pkg::CODE_W-1:0]     O_FAULT_CODE
);
  import abhl_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_MIGRATE, ST_APPEND} abhl_state_t;

  abhl_state_t state_r, state_nxt;      // Sequencer
  abhl_entry_t ent_r   [TOTAL_ROWS];    // Buffer rows then history rows
  abhl_entry_t ent_nxt [TOTAL_ROWS];    // Next row values
  abhl_entry_t pend_r;                  // Alarm waiting for a free row
  logic        pend_valid_r;            // Append after migration
  logic [3:0]  bcnt_r;                  // Rows used in buffer
  logic [3:0]  scan_r;                  // Migration scan row
  logic [31:0] count_r;                 // Alarm event counter
  logic [15:0] latest_r;                // Latest alarm code
  logic [5:0]  row_sel_r;               // Row shown on entry registers
  logic        flush_req_r;             // Counter zeroed, migrate pending
  logic [15:0] rt_days;                 // Runtime days
  logic [31:0] rt_ms;                   // Runtime milliseconds

  abhl_cfg_if cfg ();

  // Internal runtime source
  abhl_runtime #(.CYC_MS(CYC_MS)) u_runtime (
    .i_clk  (I_CLOCK),
    .i_rst  (I_RST),
    .o_days (rt_days),
    .o_ms   (rt_ms)
  );

  // Reclassification slots
  abhl_reclass u_reclass (
    .i_clk (I_CLOCK),
    .i_rst (I_RST),
    .cfg   (cfg)
  );

  // Wishbone decode; writes land on the edge that raises ack
  wire       wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  wire       wb_wr  = wb_req && I_WB_WE;
  wire [7:0] adr    = {I_WB_ADR[7:2], 2'b00};
  wire       in_sel = (adr >= OFS_SEL_BASE) && (adr < OFS_TYPE_BASE);
  wire       in_typ = (adr >= OFS_TYPE_BASE) &&
                      (adr < OFS_TYPE_BASE + 8'(4 * RECLASS_SLOTS));
  wire [7:0] slot_ofs = in_sel ? adr - OFS_SEL_BASE : adr - OFS_TYPE_BASE;
  wire [31:0] count_wr = abhl_merge(count_r, I_WB_DAT, I_WB_SEL);
  wire       cnt_write = wb_wr && (adr == OFS_COUNTER);
  wire       cnt_zero  = cnt_write && (count_wr == 32'h0000_0000);

  assign cfg.wr_sel    = wb_wr && in_sel;
  assign cfg.wr_type   = wb_wr && in_typ;
  assign cfg.idx       = slot_ofs[6:2];
  assign cfg.wr_data   = I_WB_DAT;
  assign cfg.wr_be     = I_WB_SEL;
  assign cfg.look_code = I_ALM_CODE;

  // Arrival classification; only plain alarms are logged
  // Ready gates intake: nothing is taken while ready still shows low
  wire take     = (state_r == ST_IDLE) && O_ALM_READY;
  wire raise    = take && I_ALM_VALID;
  wire log_alm  = raise && (cfg.look_type == MSG_ALARM);
  wire fault_ev = raise && (cfg.look_type == MSG_FAULT);
  wire buf_full = (bcnt_r == 4'(BUF_DEPTH));
  wire clr_ev   = take && I_CLR_VALID;
  wire start_mig = take && (flush_req_r || (log_alm && buf_full));

  // Alarm just arrived, stamped from the runtime
  abhl_entry_t new_ent;
  assign new_ent = '{valid: 1'b1, removed: 1'b0, code: I_ALM_CODE,
                     vint: I_ALM_VAL_INT, vflt: I_ALM_VAL_FLT,
                     rx_days: rt_days, rx_ms: rt_ms,
                     rm_days: 16'h0000, rm_ms: 32'h0000_0000};

  // Migration step decisions
  wire scan_done = (scan_r >= bcnt_r);
  wire scan_rm   = (state_r == ST_MIGRATE) && !scan_done &&
                   ent_r[scan_r[2:0]].removed;
  wire [3:0] app_row = buf_full ? 4'(BUF_DEPTH - 1) : bcnt_r;
  wire direct_app = log_alm && !buf_full && !flush_req_r;
  wire late_app   = (state_r == ST_APPEND);
  abhl_entry_t app_ent;
  assign app_ent = late_app ? pend_r : new_ent;
  wire do_app = direct_app || late_app;

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start_mig) begin
          state_nxt = ST_MIGRATE;
        end
      end
      ST_MIGRATE: begin
        if (scan_done) begin
          state_nxt = pend_valid_r ? ST_APPEND : ST_IDLE;
        end
      end
      ST_APPEND: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Next value of every row
  for (genvar k = 0; k < TOTAL_ROWS; k++) begin : g_row
    always_comb begin
      ent_nxt[k] = ent_r[k];
      if (k < BUF_DEPTH) begin
        // Cause gone: stamp removal time, no outside event needed
        if (clr_ev && ent_r[k].valid && !ent_r[k].removed &&
            ent_r[k].code == I_CLR_CODE) begin
          ent_nxt[k].removed = 1'b1;
          ent_nxt[k].rm_days = rt_days;
          ent_nxt[k].rm_ms   = rt_ms;
        end
        // Close the gap by moving later rows up
        if (scan_rm && 4'(k) >= scan_r) begin
          ent_nxt[k] = (k == BUF_DEPTH - 1) ? '0
                       : ent_r[(k + 1) % TOTAL_ROWS];
        end
        if (do_app && app_row == 4'(k)) begin
          ent_nxt[k] = app_ent;
        end
      end else if (scan_rm) begin
        if (k == HIST_FIRST) begin
          ent_nxt[k] = ent_r[scan_r[2:0]];
        end else begin
          ent_nxt[k] = ent_r[k - 1];
        end
      end
    end
    // Row storage
    always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
        ent_r[k] <= '0;
      end else begin
        ent_r[k] <= ent_nxt[k];
      end
    end
  end

  // Control registers and counters
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      state_r      <= ST_IDLE;
      pend_r       <= '0;
      pend_valid_r <= 1'b0;
      bcnt_r       <= 4'h0;
      scan_r       <= 4'h0;
      count_r      <= 32'h0000_0000;
      latest_r     <= 16'h0000;
      row_sel_r    <= 6'h00;
      flush_req_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // Zero write requests a flush; the request wins over its own clear
      if (cnt_zero) begin
        flush_req_r <= 1'b1;
      end else if (start_mig) begin
        flush_req_r <= 1'b0;
      end
      // Counter: a same-cycle write is applied, then the count adds one on top
      if (log_alm) begin
        count_r <= (cnt_write ? count_wr : count_r) + 32'h0000_0001;
      end else if (cnt_write) begin
        count_r <= count_wr;
      end
      if (log_alm) begin
        latest_r <= I_ALM_CODE;
      end
      if (wb_wr && adr == OFS_ROW_SEL && I_WB_SEL[0]) begin
        row_sel_r <= I_WB_DAT[5:0];
      end
      // Start of a migration, with or without an alarm to place
      if (start_mig) begin
        scan_r       <= 4'h0;
        pend_valid_r <= log_alm;
        pend_r       <= new_ent;
      end else if (scan_rm) begin
        bcnt_r <= bcnt_r - 4'h1;
      end else if (state_r == ST_MIGRATE && !scan_done) begin
        scan_r <= scan_r + 4'h1;
      end
      // Occupancy grows on append, capped at eight
      if (do_app && !buf_full && !start_mig) begin
        bcnt_r <= bcnt_r + 4'h1;
      end
      if (late_app) begin
        pend_valid_r <= 1'b0;
      end
    end
  end

  // Any row in the buffer still active
  logic [BUF_DEPTH-1:0] act_vec;
  for (genvar b = 0; b < BUF_DEPTH; b++) begin : g_act
    assign act_vec[b] = ent_r[b].valid && !ent_r[b].removed;
  end
  wire any_act = |act_vec;

  // Newest active row feeds the panel; a cleared latest code must not show
  logic [CODE_W-1:0] act_code;
  always_comb begin
    act_code = '0;
    for (int b = 0; b < BUF_DEPTH; b++) begin
      if (act_vec[b]) begin
        act_code = ent_r[b].code;
      end
    end
  end

  // Read mux
  abhl_entry_t rd_ent;
  assign rd_ent = ent_r[row_sel_r];
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    if (in_sel) begin
      rd_data = cfg.rd_sel;
    end else if (in_typ) begin
      rd_data = cfg.rd_type;
    end else begin
      unique case (adr)
        OFS_STATUS:    rd_data = 32'(any_act) << STATUS_ALARM_BIT;
        OFS_COUNTER:   rd_data = count_r;
        OFS_LATEST:    rd_data = 32'(latest_r);
        OFS_BUF_COUNT: rd_data = 32'(bcnt_r);
        OFS_ROW_SEL:   rd_data = 32'(row_sel_r);
        OFS_CODE:      rd_data = 32'(rd_ent.code);
        OFS_VAL_INT:   rd_data = rd_ent.vint;
        OFS_VAL_FLT:   rd_data = rd_ent.vflt;
        OFS_RX_DAYS:   rd_data = 32'(rd_ent.rx_days);
        OFS_RX_MS:     rd_data = rd_ent.rx_ms;
        OFS_RM_DAYS:   rd_data = 32'(rd_ent.rm_days);
        OFS_RM_MS:     rd_data = rd_ent.rm_ms;
        OFS_ROW_FLAGS: rd_data = {30'h0000_0000, rd_ent.removed,
                                  rd_ent.valid};
        default:       rd_data = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_WB_ACK       <= 1'b0;
      O_WB_DAT       <= 32'h0000_0000;
      O_ALM_READY    <= 1'b0;
      O_ALARM_ACTIVE <= 1'b0;
      O_PANEL_LETTER <= 8'h00;
      O_PANEL_NUM    <= 16'h0000;
      O_FAULT_STB    <= 1'b0;
      O_FAULT_CODE   <= 16'h0000;
    end else begin
      O_WB_ACK       <= wb_req;
      O_WB_DAT       <= wb_req ? rd_data : 32'h0000_0000;
      O_ALM_READY    <= (state_nxt == ST_IDLE);
      O_ALARM_ACTIVE <= any_act;
      O_PANEL_LETTER <= any_act ? PANEL_LETTER : 8'h00;
      O_PANEL_NUM    <= any_act ? act_code : 16'h0000;
      O_FAULT_STB    <= fault_ev;
      if (fault_ev) begin
        O_FAULT_CODE <= I_ALM_CODE;
      end
    end
  end
endmodule

//--- verification/abhl_properties.sv
// Purpose: Port-level checks of the alarm logger top
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound into the top from the bench file
`timescale 1ns/1ps
module abhl_properties
  import abhl_pkg::*;
#(
  parameter int CYC_MS = abhl_pkg::CYC_PER_MS  // Cycles per millisecond
) (
  // Clock and reset
  input  wire logic                        I_CLOCK,
  input  wire logic                        I_RST,
  // Wishbone
  input  wire logic                        I_WB_CYC,
  input  wire logic                        I_WB_STB,
  input  wire logic                        I_WB_WE,
  input  wire logic [31:0]                 O_WB_DAT,
  input  wire logic                        O_WB_ACK,
  // Alarm side
  input  wire logic                        I_ALM_VALID,
  input  wire logic                        O_ALM_READY,
  // Indication
  input  wire logic                        O_ALARM_ACTIVE,
  input  wire logic [7:0]                  O_PANEL_LETTER,
  input  wire logic [abhl_pkg::CODE_W-1:0] O_PANEL_NUM,
  input  wire logic                        O_FAULT_STB,
  input  wire logic [abhl_pkg::CODE_W-1:0] O_FAULT_CODE
);
  // Migration is bounded at about ten cycles; margin for slack
  localparam int MIG_MAX = 30;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  // Request answered one cycle later, ack is one pulse
  ack_answer_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("ack missing after request");
  ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  dat_quiet_a: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0)
    else $error("read data outside ack");
  // Panel shows the letter only with an active alarm
  panel_letter_a: assert property (
    O_PANEL_LETTER == (O_ALARM_ACTIVE ? PANEL_LETTER : 8'h00))
    else $error("panel letter wrong");
  panel_idle_a: assert property (!O_ALARM_ACTIVE |-> O_PANEL_NUM == '0)
    else $error("panel number without alarm");
  // Fault strobe only right after an accepted alarm
  fault_cause_a: assert property (
    O_FAULT_STB |-> $past(I_ALM_VALID && O_ALM_READY))
    else $error("fault strobe without alarm");
  fault_hold_a: assert property (!O_FAULT_STB |-> $stable(O_FAULT_CODE))
    else $error("fault code moved");
  // Ready up at first edge after reset, back after migration
  ready_boot_a: assert property ($fell(I_RST) |=> O_ALM_READY)
    else $error("ready late after reset");
  migrate_end_a: assert property (
    $fell(O_ALM_READY) |-> ##[1:MIG_MAX] O_ALM_READY)
    else $error("migration too long");
  c_fault: cover property (O_FAULT_STB);
  c_migrate: cover property ($fell(O_ALM_READY));
  c_write: cover property (O_WB_ACK && I_WB_WE);
endmodule

//--- verification/tb_top.sv
// Purpose: Self-checking bench of the alarm logger
// Assumes: Millisecond shortened to four cycles
// Notes:   Reset reads from a table, then hand-written sequences
`timescale 1ns/1ps
module tb_top;
  import abhl_pkg::*;
  localparam int CMS = 4;  // Short millisecond, keeps run small
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] exp;
  } abhl_row_t;
  // Register map just after reset
  localparam abhl_row_t ROWS [11] = '{
    '{8'h00, 32'h0}, '{8'h04, 32'h0}, '{8'h08, 32'h0}, '{8'h0C, 32'h0},
    '{8'h10, 32'h0}, '{8'h30, 32'h0}, '{8'h40, 32'h0}, '{8'h8C, 32'h0},
    '{8'h90, 32'h2}, '{8'hDC, 32'h2}, '{8'hFC, 32'h0}};
  logic        clk = 1'b0;     // System clock
  logic        rst = 1'b1;     // Held at start
  logic        cyc = 1'b0;     // Bus request
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [3:0]  bsel = 4'hF;    // Lanes of next bus access
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        alm_v = 1'b0;   // Alarm raise
  logic        clr_v = 1'b0;   // Cause gone
  logic [15:0] code = 16'h0;
  logic        rdy;
  logic        act;
  logic [7:0]  letter;
  logic [15:0] pnum;
  logic        fstb;
  logic [15:0] fcode;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_fault = 0;    // Fault strobes seen
  always #12.5 clk = ~clk;
  // Count fault strobes, one per arrival reclassified as fault
  always @(posedge clk) begin
    if (fstb === 1'b1) n_fault++;
  end
  abhl_top #(.CYC_MS(CMS)) i_abhl_top (
    .I_CLOCK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_ALM_VALID(alm_v),
    .I_ALM_CODE(code), .I_ALM_VAL_INT({code, code}),
    .I_ALM_VAL_FLT(~{code, code}), .I_CLR_VALID(clr_v),
    .I_CLR_CODE(code), .O_ALM_READY(rdy), .O_ALARM_ACTIVE(act),
    .O_PANEL_LETTER(letter), .O_PANEL_NUM(pnum), .O_FAULT_STB(fstb),
    .O_FAULT_CODE(fcode));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic hang();
    n_mismatch++;
    print_verdict();
  endtask
  // Classic cycle: held until ack is sampled, then released
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= bsel;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) hang();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Select a row, then read one of its fields
  task automatic rrow(input logic [5:0] r, input logic [7:0] a,
                      input logic [31:0] e);
    wr(8'h10, {26'h0, r});
    rd(a, e);
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (n >= 50) hang();
  endtask
  // One alarm raise or clear pulse, taken only while ready
  task automatic ev(input logic c, input logic [15:0] k);
    wait_rdy();
    alm_v <= !c;
    clr_v <= c;
    code <= k;
    @(posedge clk);
    alm_v <= 1'b0;
    clr_v <= 1'b0;
    wait_rdy();
    repeat (3) @(posedge clk);
  endtask
  initial begin
    logic [31:0] t0, t1;
    repeat (5) @(posedge clk);
    chk({rdy, ack, act, fstb}, 4'h0);
    rst <= 1'b0;
    wait_rdy();
    for (int i = 0; i < 11; i++) rd(ROWS[i].adr, ROWS[i].exp);
    // Raise, wait about eleven ms, then let the cause go
    ev(1'b0, 16'h0101);
    repeat (40) @(posedge clk);
    ev(1'b1, 16'h0101);
    chk(act, 1'b0);
    rd(8'h00, 32'h0);
    rrow(6'd0, 8'h30, 32'h3);
    wb(1'b0, 8'h24, 32'h0, t0);
    wb(1'b0, 8'h2C, 32'h0, t1);
    chk((t1 - t0) inside {[10:13]}, 1'b1);
    rd(8'h04, 32'h1);
    rd(8'h08, 32'h0101);
    // Slots: fault, none, alarm; zero type write ignored
    wr(8'h40, 32'h0202);
    wr(8'h90, 32'h1);
    wr(8'h44, 32'h0303);
    wr(8'h94, 32'h3);
    wr(8'h48, 32'h0404);
    wr(8'h98, 32'h2);
    wr(8'h94, 32'h0);
    rd(8'h94, 32'h3);
    bsel = 4'h1;
    wr(8'h4C, 32'h1234_5678);
    bsel = 4'hF;
    rd(8'h4C, 32'h0078);
    ev(1'b0, 16'h0202);
    chk(fcode, 16'h0202);
    chk(n_fault, 32'h1);
    ev(1'b0, 16'h0303);
    rd(8'h04, 32'h1);
    rd(8'h08, 32'h0101);
    ev(1'b0, 16'h0404);
    rd(8'h04, 32'h2);
    rd(8'h08, 32'h0404);
    chk(n_fault, 32'h1);
    rd(8'h00, 32'h80);
    chk({letter, pnum}, {8'h41, 16'h0404});
    rrow(6'd1, 8'h14, 32'h0404);
    rd(8'h18, 32'h0404_0404);
    rd(8'h1C, 32'hFBFB_FBFB);
    rd(8'h30, 32'h1);
    rd(8'h20, 32'h0);
    rd(8'h28, 32'h0);
    // Fill buffer, remove one, then a ninth alarm migrates
    for (int i = 0; i < 6; i++) ev(1'b0, 16'h0A00 + i[15:0]);
    rd(8'h0C, 32'h8);
    ev(1'b1, 16'h0A01);
    ev(1'b0, 16'h0B00);
    rd(8'h0C, 32'h7);
    rrow(6'd8, 8'h14, 32'h0A01);
    rrow(6'd9, 8'h14, 32'h0101);
    rrow(6'd10, 8'h30, 32'h0);
    rrow(6'd0, 8'h14, 32'h0404);
    rrow(6'd6, 8'h14, 32'h0B00);
    // Full with nothing removed: newest row overwritten
    ev(1'b0, 16'h0C00);
    ev(1'b0, 16'h0D00);
    rd(8'h0C, 32'h8);
    rrow(6'd7, 8'h14, 32'h0D00);
    rrow(6'd8, 8'h14, 32'h0A01);
    // Zero written to counter flushes removed rows
    ev(1'b1, 16'h0404);
    wr(8'h04, 32'h0);
    repeat (2) @(posedge clk);
    wait_rdy();
    rd(8'h04, 32'h0);
    rd(8'h0C, 32'h7);
    rrow(6'd8, 8'h14, 32'h0404);
    rrow(6'd0, 8'h14, 32'h0A00);
    // Overfill history so the oldest rows are dropped
    for (int i = 0; i < 57; i++) begin
      ev(1'b0, 16'h1000 + i[15:0]);
      ev(1'b1, 16'h1000 + i[15:0]);
      wr(8'h04, 32'h0);
      repeat (2) @(posedge clk);
      wait_rdy();
    end
    rrow(6'd8, 8'h14, 32'h1038);
    rrow(6'd63, 8'h14, 32'h1001);
    chk(pnum, 32'h0D00);
    // Second reset in mid-run empties everything
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_rdy();
    rd(8'h0C, 32'h0);
    rrow(6'd8, 8'h30, 32'h0);
    print_verdict();
  end
endmodule
bind abhl_top abhl_properties #(.CYC_MS(CYC_MS)) i_abhl_properties (
  .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .O_WB_DAT(O_WB_DAT),
  .O_WB_ACK(O_WB_ACK), .I_ALM_VALID(I_ALM_VALID),
  .O_ALM_READY(O_ALM_READY), .O_ALARM_ACTIVE(O_ALARM_ACTIVE),
  .O_PANEL_LETTER(O_PANEL_LETTER), .O_PANEL_NUM(O_PANEL_NUM),
  .O_FAULT_STB(O_FAULT_STB), .O_FAULT_CODE(O_FAULT_CODE));
